// ---- src/intc_pkg.sv ----
package intc_pkg;

  localparam int NSRC         = 7;
  localparam int NTRAP        = 4;
  localparam int PRIO_W       = 3;
  localparam int LVL_W        = 4;
  localparam int VEC_W        = 7;
  localparam int DATA_W       = 16;
  localparam int ADDR_W       = 3;

  // device register indexes on the link
  localparam logic [2:0] REG_PRIO_A  = 3'h0;
  localparam logic [2:0] REG_PRIO_B  = 3'h1;
  localparam logic [2:0] REG_STATUS  = 3'h2;
  localparam logic [2:0] REG_CTRL    = 3'h3;
  localparam logic [2:0] REG_FLAG    = 3'h4;
  localparam logic [2:0] REG_ENABLE  = 3'h5;

  // priority codes
  localparam logic [2:0] PRIO_OFF    = 3'h0;
  localparam logic [2:0] PRIO_LOWEST = 3'h1;
  localparam logic [2:0] PRIO_TOP    = 3'h7;
  localparam logic [2:0] PRIO_RESET  = 3'h4;
  localparam logic [3:0] USER_MAX_LEVEL = 4'h7;

  // field positions
  localparam int LEVEL_LSB    = 8;
  localparam int VEC_LSB      = 0;
  localparam int NEST_BIT     = 15;
  localparam int SRL_IPL_LSB  = 1;

  // sources: 0 fault b, 1 uart1 err, 2 uart2 err, 3 can1 tx, 4 can2 tx, 5 dma6, 6 dma7
  localparam logic [NSRC-1:0] SRC_IN_B = 7'h78;
  localparam int SRC_LSB [NSRC] = '{0, 4, 8, 8, 12, 0, 4};
  // vector numbers are arbitrary
  localparam logic [6:0] SRC_VEC [NSRC] =
    '{7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4C, 7'h4D, 7'h4E};
  localparam logic [6:0] TRAP_VEC [NTRAP] = '{7'h01, 7'h02, 7'h03, 7'h04};
  localparam logic [3:0] TRAP_LEVEL [NTRAP] = '{4'hF, 4'hE, 4'hD, 4'hC};

  // reset values and implemented-bit masks
  localparam logic [15:0] PRIO_A_RESET =
    {5'h00, PRIO_RESET, 1'b0, PRIO_RESET, 1'b0, PRIO_RESET};
  localparam logic [15:0] PRIO_B_RESET =
    {1'b0, PRIO_RESET, 1'b0, PRIO_RESET, 1'b0, PRIO_RESET, 1'b0, PRIO_RESET};
  localparam logic [15:0] PRIO_A_MASK  = 16'h0777;
  localparam logic [15:0] PRIO_B_MASK  = 16'h7777;
  localparam logic [15:0] CTRL_MASK    = 16'h800F;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMED_INTERRUPT_DISABLE_INSTR_TIME_NS  = 400;
  localparam int TIMED_INTERRUPT_DISABLE_INSTR_CYCLES   = (TIMED_INTERRUPT_DISABLE_INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMED_INTERRUPT_DISABLE_INSTR_CNT_W    = 5;

  // cpu end wishbone map (byte addresses)
  localparam logic [7:0] WB_SRL      = 8'h00;
  localparam logic [7:0] WB_PC       = 8'h04;
  localparam logic [7:0] WB_CMD      = 8'h08;
  localparam logic [7:0] WB_STAT     = 8'h0C;
  localparam logic [2:0] WB_DEV_PAGE = 3'h2;
  localparam int CMD_TIMED_INTERRUPT_DISABLE_INSTR = 0;
  localparam int CMD_RET  = 1;
  localparam int CMD_PUSH = 2;
  localparam int CMD_POP  = 3;
  localparam int STACK_DEPTH = 4;

endpackage : intc_pkg

// ---- src/intc_if.sv ----
`timescale 1ns/1ps
interface intc_if;
  import intc_pkg::*;
  logic              reg_req;
  logic              reg_we;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_ack;
  logic              irq_valid;
  logic [VEC_W-1:0]  irq_vector;
  logic [LVL_W-1:0]  irq_level;
  logic              take;
  logic              ret;
  logic [LVL_W-1:0]  cpu_level;
  logic              timed_interrupt_disable_instr_active;

  modport dev (
    input  reg_req, reg_we, reg_addr, reg_wdata, take, ret, cpu_level, timed_interrupt_disable_instr_active,
    output reg_rdata, reg_ack, irq_valid, irq_vector, irq_level
  );
  modport cpu (
    output reg_req, reg_we, reg_addr, reg_wdata, take, ret, cpu_level, timed_interrupt_disable_instr_active,
    input  reg_rdata, reg_ack, irq_valid, irq_vector, irq_level
  );
endinterface : intc_if

// ---- src/intc_device.sv ----
// Overview of operation
// - three-bit priority, 111 is level 7
// - priority 000 disables the source
// - code 001 is level 1, linear
// - all priorities reset to level 4
// - first register: uart2, uart1, fault b
// - second register: can2, can1 transmit, dma7, dma6
// - unimplemented bits ignore writes, read zero
// - status bits 11-8 show new level
// - status bits 6-0 pending vector, reset zero
// - nesting disable bit blocks nested source interrupts, not traps
// - software may give all one priority
// - software clears flag, then sets enable
// - flag still set re-enters the handler
// - return restores pc, status byte, level
// - trap handler clears its trap flag
// - cpu level 7 masks all user sources
// - traps are masked only by a cpu level at or above their own
// - timed disable blocks levels 1 to 6
// - software pops saved status to re-enable
`timescale 1ns/1ps
module intc_device
  import intc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic [intc_pkg::NSRC-1:0]  src_event_i,
  input  wire logic [intc_pkg::NTRAP-1:0] trap_event_i,
  output logic      [intc_pkg::NSRC-1:0]  src_flag_o,
  output logic      [intc_pkg::NTRAP-1:0] trap_flag_o,
  intc_if.dev                          link
);
  import intc_pkg::*;

  logic [15:0]       prio_a_reg;
  logic [15:0]       prio_b_reg;
  logic [15:0]       ctrl_reg;
  logic [NSRC-1:0]   flag_reg;
  logic [NSRC-1:0]   enable_reg;
  logic [LVL_W-1:0]  level_reg;
  logic [VEC_W-1:0]  vec_reg;
  logic              valid_reg;
  logic [15:0]       rdata_reg;
  logic              ack_reg;
  logic [2:0]        depth_reg;

  logic [15:0]       prio_a_next;
  logic [15:0]       prio_b_next;
  logic [15:0]       ctrl_wr;
  logic [15:0]       ctrl_next;
  logic [NSRC-1:0]   flag_next;
  logic [NSRC-1:0]   enable_next;
  logic [2:0]        depth_next;
  logic [15:0]       status_word;
  logic [15:0]       rdata_next;
  logic              valid_next;

  logic              wr_en;
  logic              wr_prio_a;
  logic              wr_prio_b;
  logic              wr_ctrl;
  logic              wr_flag;
  logic              wr_enable;
  logic              nest_block;

  logic [PRIO_W-1:0] src_prio [NSRC];
  logic [NSRC-1:0]   src_elig;
  logic [NTRAP-1:0]  trap_elig;
  logic              found;
  logic [LVL_W-1:0]  best_lvl;
  logic [VEC_W-1:0]  best_vec;

  // register write decode
  assign wr_en     = link.reg_req & link.reg_we;
  assign wr_prio_a = wr_en & (link.reg_addr == REG_PRIO_A);
  assign wr_prio_b = wr_en & (link.reg_addr == REG_PRIO_B);
  assign wr_ctrl   = wr_en & (link.reg_addr == REG_CTRL);
  assign wr_flag   = wr_en & (link.reg_addr == REG_FLAG);
  assign wr_enable = wr_en & (link.reg_addr == REG_ENABLE);

  // unimplemented bits masked off on write
  assign prio_a_next = wr_prio_a ? (link.reg_wdata & PRIO_A_MASK) : prio_a_reg;
  assign prio_b_next = wr_prio_b ? (link.reg_wdata & PRIO_B_MASK) : prio_b_reg;
  assign ctrl_wr     = wr_ctrl ? (link.reg_wdata & CTRL_MASK) : ctrl_reg;

  // hardware set wins over a software clear in the same cycle
  assign ctrl_next   = {ctrl_wr[15:NTRAP], ctrl_wr[NTRAP-1:0] | trap_event_i};
  assign flag_next   = (wr_flag ? link.reg_wdata[NSRC-1:0] : flag_reg) | src_event_i;
  assign enable_next = wr_enable ? link.reg_wdata[NSRC-1:0] : enable_reg;

  // service depth follows entry and return pulses
  assign depth_next = (link.take & ~link.ret & (depth_reg != 3'h7)) ? depth_reg + 3'h1 :
                      (link.ret & ~link.take & (depth_reg != 3'h0)) ? depth_reg - 3'h1 :
                      depth_reg;
  assign nest_block = ctrl_reg[NEST_BIT] & (depth_reg != 3'h0);

  // per-source priority field selection
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      assign src_prio[g] = SRC_IN_B[g] ? prio_b_reg[SRC_LSB[g] +: PRIO_W]
                                       : prio_a_reg[SRC_LSB[g] +: PRIO_W];
      // a zero field never reaches the cpu
      assign src_elig[g] = flag_reg[g] & enable_reg[g] & (src_prio[g] != PRIO_OFF)
                         & ({1'b0, src_prio[g]} > link.cpu_level)
                         & ~(link.timed_interrupt_disable_instr_active & (src_prio[g] != PRIO_TOP))
                         & ~nest_block;
    end
    for (g = 0; g < NTRAP; g++)
    begin : g_trap
      // traps sit above every user level, so software masking never reaches them
      assign trap_elig[g] = ctrl_reg[g] & (TRAP_LEVEL[g] > link.cpu_level);
    end
  endgenerate

  // highest level wins, lower index wins a tie
  always_comb
  begin
    found    = 1'b0;
    best_lvl = 4'h0;
    best_vec = 7'h00;
    for (int i = 0; i < NTRAP; i++)
    begin
      if (trap_elig[i] && (!found || (TRAP_LEVEL[i] > best_lvl)))
      begin
        found    = 1'b1;
        best_lvl = TRAP_LEVEL[i];
        best_vec = TRAP_VEC[i];
      end
    end
    for (int i = 0; i < NSRC; i++)
    begin
      // code n is level n, 7 highest
      if (src_elig[i] && (!found || ({1'b0, src_prio[i]} > best_lvl)))
      begin
        found    = 1'b1;
        best_lvl = {1'b0, src_prio[i]};
        best_vec = SRC_VEC[i];
      end
    end
  end

  // withdrawn on the entry pulse; a flag still set is presented again
  assign valid_next = found & ~link.take;

  assign status_word = {4'h0, level_reg, 1'b0, vec_reg};

  assign rdata_next =
    (link.reg_addr == REG_PRIO_A) ? prio_a_reg :
    (link.reg_addr == REG_PRIO_B) ? prio_b_reg :
    (link.reg_addr == REG_STATUS) ? status_word :
    (link.reg_addr == REG_CTRL)   ? ctrl_reg :
    (link.reg_addr == REG_FLAG)   ? {9'h000, flag_reg} :
    (link.reg_addr == REG_ENABLE) ? {9'h000, enable_reg} :
    16'h0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prio_a_reg <= PRIO_A_RESET;
      prio_b_reg <= PRIO_B_RESET;
      ctrl_reg   <= 16'h0000;
      flag_reg   <= '0;
      enable_reg <= '0;
      depth_reg  <= 3'h0;
    end
    else if (ce_i)
    begin
      prio_a_reg <= prio_a_next;
      prio_b_reg <= prio_b_next;
      ctrl_reg   <= ctrl_next;
      flag_reg   <= flag_next;
      enable_reg <= enable_next;
      depth_reg  <= depth_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_reg <= 4'h0;
      vec_reg   <= 7'h00;
      valid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      level_reg <= found ? best_lvl : 4'h0;
      vec_reg   <= found ? best_vec : 7'h00;
      valid_reg <= valid_next;
      rdata_reg <= link.reg_req ? rdata_next : rdata_reg;
      ack_reg   <= link.reg_req;
    end
  end

  assign link.irq_valid  = valid_reg;
  assign link.irq_vector = vec_reg;
  assign link.irq_level  = level_reg;
  assign link.reg_rdata  = rdata_reg;
  assign link.reg_ack    = ack_reg;
  assign src_flag_o      = flag_reg;
  assign trap_flag_o     = ctrl_reg[NTRAP-1:0];

endmodule : intc_device

// ---- src/intc_cpu_end.sv ----
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module intc_cpu_end
  import intc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [15:0] pc_o,
  output logic      [3:0]  cpu_level_o,
  output logic      [2:0]  stack_depth_o,
  intc_if.cpu              link
);
  import intc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DEV  = 3'b010,
    ST_ACK  = 3'b100
  } bus_st_e;

  bus_st_e                 st_reg;
  logic [31:0]             dat_reg;
  logic                    ack_reg;
  logic                    req_reg;
  logic                    dwe_reg;
  logic [ADDR_W-1:0]       daddr_reg;
  logic [15:0]             dwdata_reg;
  logic [7:0]              srl_reg;
  logic                    ipl3_reg;
  logic [15:0]             pc_reg;
  logic [8:0]              saved_sr_reg;
  logic [TIMED_INTERRUPT_DISABLE_INSTR_CNT_W-1:0]   timed_interrupt_disable_instr_cnt_reg;
  logic [2:0]              sp_reg;
  logic                    take_reg;
  logic                    ret_reg;
  logic [15:0]             pc_stk [STACK_DEPTH];
  logic [8:0]              sr_stk [STACK_DEPTH];

  logic                    bus_req;
  logic                    dev_hit;
  logic                    local_wr;
  logic                    wr_srl;
  logic                    wr_pc;
  logic                    wr_cmd;
  logic                    do_take;
  logic                    do_ret;
  logic                    do_push;
  logic                    do_pop;
  logic [1:0]              top_idx;
  logic [LVL_W-1:0]        level;
  logic [31:0]             local_rdata;

  assign bus_req  = wb_cyc_i & wb_stb_i & (st_reg == ST_IDLE);
  assign dev_hit  = (wb_adr_i[7:5] == WB_DEV_PAGE) & (wb_adr_i[1:0] == 2'h0)
                  & (wb_adr_i[4:2] <= REG_ENABLE);
  assign local_wr = bus_req & ~dev_hit & wb_we_i & wb_sel_i[0];
  assign wr_srl   = local_wr & (wb_adr_i == WB_SRL);
  assign wr_pc    = local_wr & (wb_adr_i == WB_PC);
  assign wr_cmd   = local_wr & (wb_adr_i == WB_CMD);
  assign do_ret   = wr_cmd & wb_dat_i[CMD_RET] & (sp_reg != 3'h0);
  assign do_push  = wr_cmd & wb_dat_i[CMD_PUSH];
  assign do_pop   = wr_cmd & wb_dat_i[CMD_POP];
  assign do_take  = link.irq_valid & ~take_reg & ~local_wr
                  & (sp_reg < 3'(STACK_DEPTH));
  assign top_idx  = 2'(sp_reg - 3'h1);
  assign level    = {ipl3_reg, srl_reg[SRL_IPL_LSB +: 3]};

  assign local_rdata =
    (wb_adr_i == WB_SRL)  ? {24'h000000, srl_reg} :
    (wb_adr_i == WB_PC)   ? {16'h0000, pc_reg} :
    (wb_adr_i == WB_STAT) ? {22'h000000, (timed_interrupt_disable_instr_cnt_reg != '0), sp_reg,
                             link.irq_valid, ipl3_reg, level} :
    32'h00000000;

  // wishbone slave: local answer in one cycle, device answer after its ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg     <= ST_IDLE;
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h00000000;
      req_reg    <= 1'b0;
      dwe_reg    <= 1'b0;
      daddr_reg  <= 3'h0;
      dwdata_reg <= 16'h0000;
    end
    else if (ce_i)
    begin
      case (st_reg)
        ST_IDLE:
        begin
          if (bus_req && dev_hit)
          begin
            req_reg    <= 1'b1;
            dwe_reg    <= wb_we_i & (&wb_sel_i[1:0]);
            daddr_reg  <= wb_adr_i[4:2];
            dwdata_reg <= wb_dat_i[15:0];
            st_reg     <= ST_DEV;
          end
          else if (bus_req)
          begin
            dat_reg <= local_rdata;
            ack_reg <= 1'b1;
            st_reg  <= ST_ACK;
          end
        end
        ST_DEV:
        begin
          req_reg <= 1'b0;
          if (link.reg_ack)
          begin
            dat_reg <= {16'h0000, link.reg_rdata};
            ack_reg <= 1'b1;
            st_reg  <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          ack_reg <= 1'b0;
          st_reg  <= ST_IDLE;
        end
        default:
        begin
          ack_reg <= 1'b0;
          req_reg <= 1'b0;
          st_reg  <= ST_IDLE;
        end
      endcase
    end
  end

  // core state: entry stacks pc and status, return unstacks them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srl_reg      <= 8'h00;
      ipl3_reg     <= 1'b0;
      pc_reg       <= 16'h0000;
      saved_sr_reg <= 9'h000;
      sp_reg       <= 3'h0;
      take_reg     <= 1'b0;
      ret_reg      <= 1'b0;
      timed_interrupt_disable_instr_cnt_reg <= '0;
    end
    else if (ce_i)
    begin
      take_reg <= do_take;
      ret_reg  <= do_ret;
      if (do_take)
      begin
        pc_stk[sp_reg[1:0]] <= pc_reg;
        sr_stk[sp_reg[1:0]] <= {ipl3_reg, srl_reg};
        sp_reg              <= sp_reg + 3'h1;
        pc_reg              <= {8'h00, link.irq_vector, 1'b0};
        ipl3_reg            <= link.irq_level[3];
        srl_reg[SRL_IPL_LSB +: 3] <= link.irq_level[2:0];
      end
      else if (do_ret)
      begin
        pc_reg   <= pc_stk[top_idx];
        {ipl3_reg, srl_reg} <= sr_stk[top_idx];
        sp_reg   <= sp_reg - 3'h1;
      end
      else if (do_pop)
      begin
        {ipl3_reg, srl_reg} <= saved_sr_reg;
      end
      else
      begin
        if (wr_srl)
        begin
          srl_reg <= wb_dat_i[7:0];
        end
        if (wr_pc)
        begin
          pc_reg <= wb_dat_i[15:0];
        end
      end
      if (do_push)
      begin
        saved_sr_reg <= {ipl3_reg, srl_reg};
      end
      if (wr_cmd && wb_dat_i[CMD_TIMED_INTERRUPT_DISABLE_INSTR])
      begin
        timed_interrupt_disable_instr_cnt_reg <= TIMED_INTERRUPT_DISABLE_INSTR_CNT_W'(TIMED_INTERRUPT_DISABLE_INSTR_CYCLES);
      end
      else if (timed_interrupt_disable_instr_cnt_reg != '0)
      begin
        timed_interrupt_disable_instr_cnt_reg <= timed_interrupt_disable_instr_cnt_reg - TIMED_INTERRUPT_DISABLE_INSTR_CNT_W'(1);
      end
    end
  end

  assign link.reg_req     = req_reg;
  assign link.reg_we      = dwe_reg;
  assign link.reg_addr    = daddr_reg;
  assign link.reg_wdata   = dwdata_reg;
  assign link.take        = take_reg;
  assign link.ret         = ret_reg;
  assign link.cpu_level   = level;
  assign link.timed_interrupt_disable_instr_active = (timed_interrupt_disable_instr_cnt_reg != '0);
  assign wb_dat_o         = dat_reg;
  assign wb_ack_o         = ack_reg;
  assign pc_o             = pc_reg;
  assign cpu_level_o      = level;
  assign stack_depth_o    = sp_reg;

endmodule : intc_cpu_end

// ---- tb/intc_monitor.sv ----
`timescale 1ns/1ps
module intc_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [2:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        irq_valid,
  input wire logic [6:0]  irq_vector,
  input wire logic [3:0]  irq_level,
  input wire logic        take,
  input wire logic        ret,
  input wire logic [3:0]  cpu_level,
  input wire logic        timed_interrupt_disable_instr_active
);
  import intc_pkg::*;
  logic [4:0] timed_interrupt_disable_instr_cnt_reg;
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // length of the running timed disable
  always_ff @(posedge clk_i)
    timed_interrupt_disable_instr_cnt_reg <= (rst_i || !timed_interrupt_disable_instr_active) ? 5'h00 : timed_interrupt_disable_instr_cnt_reg + 5'h01;
  link_ack_a: assert property (reg_req |=> reg_ack)
    else $error("link request without answer");
  status_pad_a: assert property (reg_req && !reg_we && reg_addr == REG_STATUS |=>
    reg_rdata[15:12] == 4'h0 && !reg_rdata[7]) else $error("status pad bits set");
  prio_pad_a: assert property (reg_req && !reg_we && reg_addr == REG_PRIO_A |=>
    (reg_rdata & ~PRIO_A_MASK) == 16'h0000) else $error("priority pad bits set");
  above_level_a: assert property (irq_valid |-> irq_level > $past(cpu_level))
    else $error("interrupt not above cpu level");
  timed_interrupt_disable_instr_block_a: assert property ($past(timed_interrupt_disable_instr_active) && irq_valid &&
    irq_level <= USER_MAX_LEVEL |-> irq_level == USER_MAX_LEVEL) else $error("timed_interrupt_disable_instr leak");
  timed_interrupt_disable_instr_len_a: assert property ($fell(timed_interrupt_disable_instr_active) |-> timed_interrupt_disable_instr_cnt_reg == 5'h10)
    else $error("timed disable length wrong");
  take_valid_a: assert property (take |-> $past(irq_valid) ##1 !irq_valid)
    else $error("take without presented interrupt");
  take_level_a: assert property (take |-> cpu_level == $past(irq_level))
    else $error("cpu level not raised on entry");
  take_gap_a: assert property (take |=> !take)
    else $error("back to back take");
  trap_vec_a: assert property (irq_valid && irq_level == 4'hF |->
    irq_vector == TRAP_VEC[0]) else $error("trap vector wrong");
endmodule : intc_monitor

// ---- tb/test_interrupt_priority_and_status.sv ----
`timescale 1ns/1ps
module test_interrupt_priority_and_status;
  import intc_pkg::*;
  localparam logic [7:0] A_PA = {WB_DEV_PAGE, REG_PRIO_A, 2'b00};
  localparam logic [7:0] A_PB = {WB_DEV_PAGE, REG_PRIO_B, 2'b00};
  localparam logic [7:0] A_ST = {WB_DEV_PAGE, REG_STATUS, 2'b00};
  localparam logic [7:0] A_CT = {WB_DEV_PAGE, REG_CTRL, 2'b00};
  localparam logic [7:0] A_FL = {WB_DEV_PAGE, REG_FLAG, 2'b00};
  localparam logic [7:0] A_EN = {WB_DEV_PAGE, REG_ENABLE, 2'b00};
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_req   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [31:0] wb_dat   = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [15:0] pc;
  logic [3:0]  lvl;
  logic [6:0]  sflag;
  logic [3:0]  tflag;
  logic [2:0]  sdep;
  logic [6:0]  src_ev   = 7'h00;
  logic [3:0]  trap_ev  = 4'h0;
  logic [31:0] rng      = 32'h79A7;
  logic [63:0] rq;
  logic [10:0] tq;
  logic [63:0] rd_q[$];
  logic [10:0] tk_q[$];
  int          errors   = 0;
  int          compares = 0;
  intc_if link_if ();
  intc_device intc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .src_event_i(src_ev), .trap_event_i(trap_ev), .src_flag_o(sflag), .trap_flag_o(tflag),
    .link(link_if.dev));
  intc_cpu_end intc_cpu_end_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .pc_o(pc), .cpu_level_o(lvl), .stack_depth_o(sdep), .link(link_if.cpu));
  intc_monitor intc_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .reg_req(link_if.reg_req), .reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata),
    .reg_ack(link_if.reg_ack), .irq_valid(link_if.irq_valid),
    .irq_vector(link_if.irq_vector), .irq_level(link_if.irq_level), .take(link_if.take),
    .ret(link_if.ret), .cpu_level(link_if.cpu_level), .timed_interrupt_disable_instr_active(link_if.timed_interrupt_disable_instr_active));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task wrap_up();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task to();
    errors++;
    $display("timeout at %0t", $time);
    wrap_up();
  endtask : to
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_req <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    for (n = 0; n < 50 && wb_ack !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 50)
      to();
    wb_req <= 1'b0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    rd_q.push_back({m, e});
    wb(a, 1'b0, 32'h0);
  endtask : rd
  task ev(input logic [6:0] s, input logic [3:0] t);
    @(posedge clk_i);
    src_ev  <= s;
    trap_ev <= t;
    @(posedge clk_i);
    src_ev  <= 7'h00;
    trap_ev <= 4'h0;
  endtask : ev
  task wq(input int k);
    int n;
    for (n = 0; n < 300 && tk_q.size() > k; n++)
      @(posedge clk_i);
    if (n == 300)
      to();
  endtask : wq
  // handler end: clear flags but keep, then return
  task svc(input logic [31:0] keep);
    wb(A_FL, 1'b1, keep);
    wb(WB_CMD, 1'b1, 32'h2);
  endtask : svc
  // watcher: reads and vector entries against the oldest note
  always @(posedge clk_i)
  begin
    if (wb_req && wb_ack && !wb_we)
    begin
      rq = rd_q.pop_front();
      chk(wb_rdat & rq[63:32], rq[31:0]);
    end
    if (link_if.take === 1'b1)
    begin
      tq = (tk_q.size() > 0) ? tk_q.pop_front() : 11'h7FF;
      chk({16'h0, pc}, {16'h0, 8'h00, tq[6:0], 1'b0});
      chk({28'h0, lvl}, {28'h0, tq[10:7]});
    end
  end
  initial
  begin
    int          i;
    int          lsb [7];
    logic [6:0]  in_b;
    logic [2:0]  c;
    logic [31:0] f;
    lsb  = '{0, 4, 8, 8, 12, 0, 4};
    in_b = 7'h78;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_PA, 32'h0444);
    rd(A_PB, 32'h4444);
    rd(A_ST, 32'h0);
    rd(8'h80, 32'h0);
    wb(A_PA, 1'b1, 32'hFFFF);
    rd(A_PA, 32'h0777);
    for (i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      wb(A_PB, 1'b1, rng);
      rd(A_PB, rng & 32'h7777);
    end
    wb(A_ST, 1'b1, 32'hFFFF);
    rd(A_ST, 32'h0);
    $display("register test done");
    for (i = 0; i < NSRC; i++)
    begin
      c = 3'(i + 1);
      f = 32'(c) << lsb[i];
      wb(A_PA, 1'b1, in_b[i] ? 32'h0 : f);
      wb(A_PB, 1'b1, in_b[i] ? f : 32'h0);
      wb(A_FL, 1'b1, 32'h0);
      wb(A_EN, 1'b1, 32'(1 << i));
      tk_q.push_back({1'b0, c, SRC_VEC[i]});
      // status is read while the source stands presented, before entry
      fork
        ev(7'(1 << i), 4'h0);
        begin
          @(posedge clk_i);
          rd(A_ST, 32'({1'b0, c, 1'b0, SRC_VEC[i]}));
        end
      join
      wq(0);
      chk({29'h0, sdep}, 32'h1);
      rd(WB_STAT, 32'(c) | 32'h40);
      svc(32'h0);
      rd(WB_STAT, 32'h0);
    end
    wb(A_PA, 1'b1, 32'h0);
    wb(A_EN, 1'b1, 32'h1);
    ev(7'h01, 4'h0);
    repeat (30) @(posedge clk_i);
    chk({16'h0, pc}, 32'h0);
    chk({25'h0, sflag}, 32'h1);
    wb(A_FL, 1'b1, 32'h0);
    $display("source test done");
    wb(A_PA, 1'b1, 32'h0020);
    wb(A_EN, 1'b1, 32'h2);
    tk_q.push_back({4'h2, SRC_VEC[1]});
    tk_q.push_back({4'h2, SRC_VEC[1]});
    ev(7'h02, 4'h0);
    wq(1);
    wb(WB_CMD, 1'b1, 32'h2);
    wq(0);
    svc(32'h0);
    $display("reentry test done");
    wb(A_PA, 1'b1, 32'h0700);
    wb(A_EN, 1'b1, 32'h4);
    wb(WB_CMD, 1'b1, 32'h4);
    wb(WB_SRL, 1'b1, 32'hE);
    rd(WB_STAT, 32'h7, 32'hF);
    ev(7'h04, 4'h0);
    repeat (30) @(posedge clk_i);
    tk_q.push_back({TRAP_LEVEL[0], TRAP_VEC[0]});
    ev(7'h00, 4'h1);
    wq(0);
    chk({28'h0, tflag}, 32'h1);
    wb(A_CT, 1'b1, 32'h0);
    chk({28'h0, tflag}, 32'h0);
    wb(WB_CMD, 1'b1, 32'h2);
    tk_q.push_back({4'h7, SRC_VEC[2]});
    wb(WB_CMD, 1'b1, 32'h8);
    wq(0);
    svc(32'h0);
    $display("mask test done");
    wb(A_PB, 1'b1, 32'h0075);
    wb(A_EN, 1'b1, 32'h60);
    wb(WB_CMD, 1'b1, 32'h1);
    tk_q.push_back({4'h5, SRC_VEC[5]});
    ev(7'h20, 4'h0);
    repeat (8) @(posedge clk_i);
    chk(32'(tk_q.size()), 32'h1);
    wq(0);
    svc(32'h0);
    wb(WB_CMD, 1'b1, 32'h1);
    tk_q.push_back({4'h7, SRC_VEC[6]});
    ev(7'h40, 4'h0);
    wq(0);
    chk({31'h0, link_if.timed_interrupt_disable_instr_active}, 32'h1);
    svc(32'h0);
    repeat (20) @(posedge clk_i);
    $display("timed disable test done");
    wb(A_CT, 1'b1, 32'h8000);
    wb(A_PA, 1'b1, 32'h0030);
    wb(A_PB, 1'b1, 32'h0600);
    wb(A_EN, 1'b1, 32'h0A);
    tk_q.push_back({4'h3, SRC_VEC[1]});
    ev(7'h02, 4'h0);
    wq(0);
    tk_q.push_back({4'h6, SRC_VEC[3]});
    ev(7'h08, 4'h0);
    repeat (30) @(posedge clk_i);
    chk(32'(tk_q.size()), 32'h1);
    svc(32'h8);
    wq(0);
    svc(32'h0);
    wb(A_CT, 1'b1, 32'h0);
    $display("nesting test done");
    // one shared level: tie goes to the lower index, the other follows on return
    wb(A_PA, 1'b1, 32'h0333);
    wb(A_EN, 1'b1, 32'h03);
    tk_q.push_back({4'h3, SRC_VEC[0]});
    tk_q.push_back({4'h3, SRC_VEC[1]});
    ev(7'h03, 4'h0);
    wq(1);
    svc(32'h2);
    wq(0);
    svc(32'h0);
    $display("single level test done");
    wrap_up();
  end
endmodule : test_interrupt_priority_and_status
